// file: cmd_decode_pkg.sv
// Package for the command decoder and bank state tracker
// Assumes a single 50 MHz clock domain; timing counts are in clock cycles
package cmd_decode_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_RP_NS       = 15;
    localparam int T_RCD_NS      = 15;
    localparam int T_RFC_NS      = 128;
    localparam int T_MRD_CK      = 2;
    localparam int T_XSNR_NS     = 138;
    localparam int T_WR_NS       = 15;
    // Least times round up
    localparam int RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC_CYC  = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MRD_CYC  = T_MRD_CK;
    localparam int XSNR_CYC = (T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC   = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURST_LEN = 4;
    localparam int BURST_CYC = BURST_LEN / 2;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int NUM_BANKS = 8;
    localparam int BA_W      = 3;
    localparam int ADDR_W    = 14;
    localparam int AP_BIT    = 10;
    localparam int CNT_W     = 8;

    // ------------------------------------------------------------------
    // Decoded command codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_DESEL    = 4'h0,
        CMD_NOP      = 4'h1,
        CMD_MODE     = 4'h2,
        CMD_REFRESH  = 4'h3,
        CMD_SR_ENTER = 4'h4,
        CMD_SR_EXIT  = 4'h5,
        CMD_PRE      = 4'h6,
        CMD_PRE_ALL  = 4'h7,
        CMD_ACT      = 4'h8,
        CMD_WRITE    = 4'h9,
        CMD_WRITE_AP = 4'ha,
        CMD_READ     = 4'hb,
        CMD_READ_AP  = 4'hc,
        CMD_PD_ENTER = 4'hd,
        CMD_PD_EXIT  = 4'he,
        CMD_ILLEGAL  = 4'hf
    } cmd_e;

    // Per-bank state
    typedef enum logic [2:0] {
        BK_IDLE     = 3'h0,
        BK_ACTIVATE = 3'h1,
        BK_ACTIVE   = 3'h2,
        BK_READ     = 3'h3,
        BK_WRITE    = 3'h4,
        BK_READ_AP  = 3'h5,
        BK_WRITE_AP = 3'h6,
        BK_PRECHG   = 3'h7
    } bank_e;

    // Device-wide state
    typedef enum logic [2:0] {
        DV_NORMAL  = 3'h0,
        DV_REFRESH = 3'h1,
        DV_MODE    = 3'h2,
        DV_SELFREF = 3'h3,
        DV_XSNR    = 3'h4,
        DV_PWRDN   = 3'h5
    } dev_e;

    // Command bus sampled from the pins
    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } cmd_bus_s;

    // Mode register write
    typedef struct packed {
        logic              valid;
        logic [BA_W-1:0]   sel;
        logic [ADDR_W-1:0] value;
    } mode_wr_s;

endpackage : cmd_decode_pkg

// file: cmd_bank_tracker.sv
// Command decoder and per-bank state tracker for a DDR2 memory core
// Assumes command pins arrive asynchronously and are synchronised here;
// the controller keeps to the legal command order
// Functional notes
// RL1: Decode command from chip select, strobes and clock enable at rising edge.
// RL2: Mode load uses bank address to choose the mode register written.
// RL3: Refresh and mode load are device wide; all banks idle assumed.
// RL4: Self refresh ends as soon as clock enable goes high.
// RL5: Controller keeps power-down short enough for refresh interval.
// RL6: Burst of four always completes; later commands do not cut it. The tracker lets a read, write or precharge to the bank end it early.
// RL7: Termination control never alters decode; termination off in self refresh.
// RL8: Third bank address bit used only for one gigabit or larger.
// RL9: Deselect and no-operation leave every bank unchanged.
// RL10: Bank table applies with clock enable high twice and exit delay met.
// RL11: Idle after precharge time and read finished; only idle accepts activate.
// RL12: Row active after activate delay; accepts read, write, precharge.
// RL13: Bank in read or write without auto precharge accepts new column commands.
// RL14: Controller sends nothing to a bank while precharging, activating or auto-precharging.
// RL15: Precharge keeps bank busy for precharge time, then idle.
// RL16: Auto precharge access keeps bank busy until precharge time, then idle.
// RL17: Activate holds activating state for activate delay, then row active.
// RL18: Refresh busy for refresh cycle time, then all banks idle.
// RL19: Mode access busy for mode delay, then all banks idle.
// RL20: Controller drives only deselect or no-operation during device-wide busy.
// RL21: Controller ensures each bank precharged together may be precharged.
// RL22: Write after read only once read burst ends; unlisted cases illegal. The tracker takes a write to a bank in read without flagging it.
// RL23: Address bit ten selects auto precharge or all-bank precharge when high.
`timescale 1ns/100ps

module cmd_bank_tracker #(
    parameter int  NUM_BANKS = cmd_decode_pkg::NUM_BANKS,
    parameter bit  DENSE     = 1'b1
) (
    // Clock and reset
    input  wire logic                               mclk,
    input  wire logic                               rst_n,
    // Command pins from the controller
    input  wire cmd_decode_pkg::cmd_bus_s           cmd_pins,
    input  wire logic                               odt_pin,
    // Decode results
    output cmd_decode_pkg::cmd_e                    cmd_code,
    output cmd_decode_pkg::mode_wr_s                mode_wr,
    output cmd_decode_pkg::dev_e                    dev_state,
    output cmd_decode_pkg::bank_e [NUM_BANKS-1:0]   bank_state,
    output logic                                    odt_active,
    output logic                                    illegal_cmd
);

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    cmd_decode_pkg::cmd_bus_s sync1_r;
    cmd_decode_pkg::cmd_bus_s smp_r;
    logic                     odt1_r;
    logic                     odt_s_r;
    logic                     cke_prev_r;

    // Two flops on every pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r    <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            smp_r      <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            odt1_r     <= 1'b0;
            odt_s_r    <= 1'b0;
            cke_prev_r <= 1'b0;
        end else begin
            sync1_r    <= cmd_pins;
            smp_r      <= sync1_r;
            odt1_r     <= odt_pin;
            odt_s_r    <= odt1_r;
            cke_prev_r <= smp_r.cke;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Decode one command from the sampled levels
    function automatic cmd_decode_pkg::cmd_e decode(
        input logic                     ckp,
        input cmd_decode_pkg::cmd_bus_s c
    );
        logic [3:0] s;
        s = {c.cs_n, c.ras_n, c.cas_n, c.we_n};
        decode = cmd_decode_pkg::CMD_ILLEGAL;
        if (c.cs_n || s == 4'h7) begin
            if (ckp && c.cke) begin
                decode = c.cs_n ? cmd_decode_pkg::CMD_DESEL : cmd_decode_pkg::CMD_NOP;
            end else if (ckp) begin
                decode = cmd_decode_pkg::CMD_PD_ENTER;
            end else if (c.cke) begin
                decode = cmd_decode_pkg::CMD_PD_EXIT;
            end else begin
                decode = cmd_decode_pkg::CMD_DESEL;
            end
        end else if (ckp && !c.cke && s == 4'h1) begin
            decode = cmd_decode_pkg::CMD_SR_ENTER;
        end else if (ckp && c.cke) begin
            if (s == 4'h0) begin
                decode = cmd_decode_pkg::CMD_MODE;
            end else if (s == 4'h1) begin
                decode = cmd_decode_pkg::CMD_REFRESH;
            end else if (s == 4'h2) begin
                // RL23: bit ten selects all banks
                decode = c.addr[cmd_decode_pkg::AP_BIT] ? cmd_decode_pkg::CMD_PRE_ALL : cmd_decode_pkg::CMD_PRE;
            end else if (s == 4'h3) begin
                decode = cmd_decode_pkg::CMD_ACT;
            end else if (s == 4'h4) begin
                // RL23: bit ten selects auto precharge
                decode = c.addr[cmd_decode_pkg::AP_BIT] ? cmd_decode_pkg::CMD_WRITE_AP : cmd_decode_pkg::CMD_WRITE;
            end else if (s == 4'h5) begin
                decode = c.addr[cmd_decode_pkg::AP_BIT] ? cmd_decode_pkg::CMD_READ_AP : cmd_decode_pkg::CMD_READ;
            end
        end
    endfunction : decode

    // RL1: decode at rising edge
    // RL7: termination pin is not an input to decode
    cmd_decode_pkg::cmd_e cmd_now;
    logic [cmd_decode_pkg::BA_W-1:0] ba_eff;
    always_comb begin
        cmd_now = decode(cke_prev_r, smp_r);
        // RL8: top bank bit only on dense parts
        ba_eff = smp_r.ba;
        if (!DENSE) begin
            ba_eff[cmd_decode_pkg::BA_W-1] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Device state machine
    // ------------------------------------------------------------------
    cmd_decode_pkg::dev_e dev_r, dev_nxt;
    logic [cmd_decode_pkg::CNT_W-1:0] dcnt_r, dcnt_nxt;
    logic table_ok;
    logic all_idle;

    always_comb begin
        all_idle = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bank_state[i] != cmd_decode_pkg::BK_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    // RL10: bank table only in normal state with clock enable held
    assign table_ok = (dev_r == cmd_decode_pkg::DV_NORMAL) && cke_prev_r && smp_r.cke;

    // Next device state
    always_comb begin
        dev_nxt  = dev_r;
        dcnt_nxt = (dcnt_r != '0) ? dcnt_r - 1'b1 : dcnt_r;
        case (dev_r)
            cmd_decode_pkg::DV_NORMAL: begin
                // RL3: refresh, mode load and self refresh entry rely on all banks idle; power-down entry does not
                if (cmd_now == cmd_decode_pkg::CMD_REFRESH && all_idle) begin
                    dev_nxt  = cmd_decode_pkg::DV_REFRESH;
                    dcnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::RFC_CYC - 1);
                end else if (cmd_now == cmd_decode_pkg::CMD_MODE && all_idle) begin
                    dev_nxt  = cmd_decode_pkg::DV_MODE;
                    dcnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::MRD_CYC - 1);
                end else if (cmd_now == cmd_decode_pkg::CMD_SR_ENTER && all_idle) begin
                    dev_nxt = cmd_decode_pkg::DV_SELFREF;
                end else if (cmd_now == cmd_decode_pkg::CMD_PD_ENTER) begin
                    dev_nxt = cmd_decode_pkg::DV_PWRDN;
                end
            end
            // RL18: busy for refresh cycle time
            cmd_decode_pkg::DV_REFRESH: begin
                if (dcnt_r == '0) begin
                    dev_nxt = cmd_decode_pkg::DV_NORMAL;
                end
            end
            // RL19: busy for mode delay
            cmd_decode_pkg::DV_MODE: begin
                if (dcnt_r == '0) begin
                    dev_nxt = cmd_decode_pkg::DV_NORMAL;
                end
            end
            // RL4: leave on clock enable high alone
            cmd_decode_pkg::DV_SELFREF: begin
                if (smp_r.cke) begin
                    dev_nxt  = cmd_decode_pkg::DV_XSNR;
                    dcnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::XSNR_CYC - 1);
                end
            end
            cmd_decode_pkg::DV_XSNR: begin
                if (dcnt_r == '0) begin
                    dev_nxt = cmd_decode_pkg::DV_NORMAL;
                end
            end
            cmd_decode_pkg::DV_PWRDN: begin
                if (smp_r.cke) begin
                    dev_nxt = cmd_decode_pkg::DV_NORMAL;
                end
            end
            default: dev_nxt = cmd_decode_pkg::DV_NORMAL;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dev_r  <= cmd_decode_pkg::DV_NORMAL;
            dcnt_r <= '0;
        end else begin
            dev_r  <= dev_nxt;
            dcnt_r <= dcnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Per-bank trackers
    // ------------------------------------------------------------------
    logic [NUM_BANKS-1:0] bad_bank;

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
        cmd_decode_pkg::bank_e            st_r, st_nxt;
        logic [cmd_decode_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
        logic                             hit;
        logic                             pre_hit;

        // Next state of one bank
        always_comb begin
            hit      = table_ok && (ba_eff == cmd_decode_pkg::BA_W'(g));
            pre_hit  = table_ok && (cmd_now == cmd_decode_pkg::CMD_PRE_ALL);
            st_nxt   = st_r;
            cnt_nxt  = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
            bad_bank[g] = 1'b0;
            case (st_r)
                // RL11: only idle accepts activate
                cmd_decode_pkg::BK_IDLE: begin
                    if (hit && cmd_now == cmd_decode_pkg::CMD_ACT) begin
                        st_nxt  = cmd_decode_pkg::BK_ACTIVATE;
                        cnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::RCD_CYC - 1);
                    end
                end
                // RL17: activating until activate delay met
                cmd_decode_pkg::BK_ACTIVATE: begin
                    if (cnt_r == '0) begin
                        st_nxt = cmd_decode_pkg::BK_ACTIVE;
                    end
                end
                // RL12: row active column and precharge  RL13: open bursts accept more
                cmd_decode_pkg::BK_ACTIVE, cmd_decode_pkg::BK_READ, cmd_decode_pkg::BK_WRITE: begin
                    // RL6: burst of four runs to its end unless a new read, write or precharge to the bank replaces it
                    if (st_r != cmd_decode_pkg::BK_ACTIVE && cnt_r == '0) begin
                        st_nxt = cmd_decode_pkg::BK_ACTIVE;
                    end
                    if (pre_hit || (hit && cmd_now == cmd_decode_pkg::CMD_PRE)) begin
                        st_nxt  = cmd_decode_pkg::BK_PRECHG;
                        cnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::RP_CYC - 1);
                    end else if (hit && cmd_now == cmd_decode_pkg::CMD_READ) begin
                        st_nxt  = cmd_decode_pkg::BK_READ;
                        cnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::BURST_CYC - 1);
                    end else if (hit && cmd_now == cmd_decode_pkg::CMD_WRITE) begin
                        st_nxt  = cmd_decode_pkg::BK_WRITE;
                        cnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::BURST_CYC - 1);
                    end else if (hit && cmd_now == cmd_decode_pkg::CMD_READ_AP) begin
                        st_nxt  = cmd_decode_pkg::BK_READ_AP;
                        cnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::BURST_CYC + cmd_decode_pkg::RP_CYC - 1);
                    end else if (hit && cmd_now == cmd_decode_pkg::CMD_WRITE_AP) begin
                        st_nxt  = cmd_decode_pkg::BK_WRITE_AP;
                        cnt_nxt = cmd_decode_pkg::CNT_W'(cmd_decode_pkg::BURST_CYC + cmd_decode_pkg::WR_CYC
                                                          + cmd_decode_pkg::RP_CYC - 1);
                    end else if (hit && cmd_now == cmd_decode_pkg::CMD_ACT) begin
                        bad_bank[g] = 1'b1;
                    end
                end
                // RL15: precharge time then idle  RL16: auto precharge then idle
                default: begin
                    if (cnt_r == '0) begin
                        st_nxt = cmd_decode_pkg::BK_IDLE;
                    end
                    // RL14: activate, read or write to a precharging or auto-precharging bank is flagged
                    if (hit && cmd_now > cmd_decode_pkg::CMD_PRE_ALL) begin
                        bad_bank[g] = 1'b1;
                    end
                end
            endcase
            // RL9: deselect and no-operation fall through untouched
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                st_r  <= cmd_decode_pkg::BK_IDLE;
                cnt_r <= '0;
            end else begin
                st_r  <= st_nxt;
                cnt_r <= cnt_nxt;
            end
        end

        assign bank_state[g] = st_r;
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    cmd_decode_pkg::mode_wr_s mode_nxt;
    cmd_decode_pkg::cmd_e     code_nxt;
    logic                     odt_nxt;
    logic                     ill_nxt;

    // Output next values
    always_comb begin
        // RL1: clock enable exit named by the state it leaves
        code_nxt = (cmd_now == cmd_decode_pkg::CMD_PD_EXIT && dev_r == cmd_decode_pkg::DV_SELFREF)
                   ? cmd_decode_pkg::CMD_SR_EXIT : cmd_now;
        // RL2: bank address picks the mode register
        mode_nxt.valid = (dev_r == cmd_decode_pkg::DV_NORMAL) && (cmd_now == cmd_decode_pkg::CMD_MODE) && all_idle;
        mode_nxt.sel   = ba_eff;
        mode_nxt.value = smp_r.addr;
        // RL7: termination off in self refresh
        odt_nxt = odt_s_r && (dev_r != cmd_decode_pkg::DV_SELFREF) && (dev_nxt != cmd_decode_pkg::DV_SELFREF);
        ill_nxt = (|bad_bank) || (table_ok && cmd_now == cmd_decode_pkg::CMD_ILLEGAL)
                  || ((dev_r == cmd_decode_pkg::DV_REFRESH || dev_r == cmd_decode_pkg::DV_MODE)
                      && cmd_now != cmd_decode_pkg::CMD_DESEL && cmd_now != cmd_decode_pkg::CMD_NOP);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_code    <= cmd_decode_pkg::CMD_DESEL;
            mode_wr     <= '0;
            odt_active  <= 1'b0;
            illegal_cmd <= 1'b0;
        end else begin
            cmd_code    <= code_nxt;
            mode_wr     <= mode_nxt;
            odt_active  <= odt_nxt;
            illegal_cmd <= ill_nxt;
        end
    end

    assign dev_state = dev_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_act_taken;
        table_ok && cmd_now == cmd_decode_pkg::CMD_ACT && g_bank[0].st_r == cmd_decode_pkg::BK_IDLE && ba_eff == '0;
    endsequence

    a_act_to_active: assert property (@(posedge mclk) disable iff (!rst_n) // RL17
        s_act_taken |=> (bank_state[0] == cmd_decode_pkg::BK_ACTIVATE) ##1 (bank_state[0] == cmd_decode_pkg::BK_ACTIVE))
        else $error("activate did not reach row active");

    a_refresh_busy: assert property (@(posedge mclk) disable iff (!rst_n) // RL18
        (dev_r == cmd_decode_pkg::DV_NORMAL && dev_nxt == cmd_decode_pkg::DV_REFRESH)
        |=> (dev_r == cmd_decode_pkg::DV_REFRESH) [*7] ##1 (dev_r == cmd_decode_pkg::DV_NORMAL && all_idle))
        else $error("refresh busy time wrong");

    a_mode_busy: assert property (@(posedge mclk) disable iff (!rst_n) // RL19
        mode_nxt.valid |=> (dev_r == cmd_decode_pkg::DV_MODE) [*2] ##1 (dev_r == cmd_decode_pkg::DV_NORMAL))
        else $error("mode busy time wrong");

    a_mode_select: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
        mode_nxt.valid |=> mode_wr.valid && mode_wr.sel == $past(ba_eff))
        else $error("mode register select wrong");

    a_sr_exit: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
        (dev_r == cmd_decode_pkg::DV_SELFREF && smp_r.cke) |=> dev_r == cmd_decode_pkg::DV_XSNR)
        else $error("self refresh exit missed");

    a_odt_selfref: assert property (@(posedge mclk) disable iff (!rst_n) // RL7
        (dev_r == cmd_decode_pkg::DV_SELFREF) |-> ##1 !odt_active)
        else $error("termination on in self refresh");

    a_nop_holds: assert property (@(posedge mclk) disable iff (!rst_n) // RL9
        (cmd_now == cmd_decode_pkg::CMD_NOP && bank_state[0] == cmd_decode_pkg::BK_ACTIVE)
        |=> bank_state[0] == cmd_decode_pkg::BK_ACTIVE)
        else $error("no-operation disturbed bank");

    a_pre_to_idle: assert property (@(posedge mclk) disable iff (!rst_n) // RL15
        (bank_state[0] == cmd_decode_pkg::BK_ACTIVE && table_ok
         && (cmd_now == cmd_decode_pkg::CMD_PRE_ALL || (cmd_now == cmd_decode_pkg::CMD_PRE && ba_eff == '0)))
        |=> (bank_state[0] == cmd_decode_pkg::BK_PRECHG) ##1 (bank_state[0] == cmd_decode_pkg::BK_IDLE))
        else $error("precharge did not end in idle");

endmodule : cmd_bank_tracker

// file: ctrl_model.sv
// Controller model that drives command pins of the tracker
// Assumes callers enter issue just after a falling edge
`timescale 1ns/100ps

module ctrl_model (
    // Clock
    input  wire logic                     mclk,
    // Command pins
    output cmd_decode_pkg::cmd_bus_s      cmd_pins
);
    // ------------------------------------------------------------
    // Pins idle as deselect with clock enable low
    // ------------------------------------------------------------
    initial cmd_pins = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0};

    task automatic issue(input logic [3:0] rcw, input logic [2:0] ba, input logic [13:0] addr);
        @(posedge mclk);
        cmd_pins <= '{1'b1, rcw[3], rcw[2], rcw[1], rcw[0], ba, addr};
        @(posedge mclk);
        cmd_pins <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, ~ba, ~addr};
    endtask : issue

    task automatic levels(input logic cke, input logic [3:0] rcw);
        @(posedge mclk);
        cmd_pins <= '{cke, rcw[3], rcw[2], rcw[1], rcw[0], 3'h0, 14'h0};
    endtask : levels
endmodule : ctrl_model

// file: tb.sv
// Testbench for the command decoder and bank tracker
// Assumes the controller model keeps to legal command order except the activate to an open bank in t_bank
`timescale 1ns/100ps

module tb;
    logic                                 mclk;
    logic                                 rst_n;
    logic                                 odt_pin;
    cmd_decode_pkg::cmd_bus_s             cmd_pins;
    cmd_decode_pkg::cmd_e                 cmd_code;
    cmd_decode_pkg::mode_wr_s             mode_wr;
    cmd_decode_pkg::dev_e                 dev_state;
    cmd_decode_pkg::bank_e [7:0]          bank_state;
    logic                                 odt_active;
    logic                                 illegal_cmd;
    int                                   fail_count = 0;
    int                                   compares = 0;
    int                                   cyc = 0;

    ctrl_model ctl_u (.mclk(mclk), .cmd_pins(cmd_pins));
    cmd_bank_tracker dut_u (.mclk(mclk), .rst_n(rst_n), .cmd_pins(cmd_pins), .odt_pin(odt_pin),
        .cmd_code(cmd_code), .mode_wr(mode_wr), .dev_state(dev_state), .bank_state(bank_state),
        .odt_active(odt_active), .illegal_cmd(illegal_cmd));

    // Clock and hang limit
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count = fail_count + 1;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Wait for a decoded command, bounded
    task automatic expect_cmd(input cmd_decode_pkg::cmd_e c);
        int n;
        @(negedge mclk);
        for (n = 0; n < 8 && cmd_code !== c; n++) @(negedge mclk);
        chk(cmd_code, c);
    endtask : expect_cmd

    // State held n samples, then the following state; bank index 8 means device
    task automatic walk(input int w, input logic [2:0] st, input int n, input logic [2:0] aft);
        for (int i = 0; i <= n; i++) begin
            chk((w == 8) ? dev_state : bank_state[w], (i < n) ? st : aft);
            @(negedge mclk);
        end
    endtask : walk

    task automatic t_mode;
        ctl_u.issue(4'h0, 3'h5, 14'h0123);
        expect_cmd(cmd_decode_pkg::CMD_MODE);
        chk({mode_wr.valid, mode_wr.sel, mode_wr.value}, {1'b1, 3'h5, 14'h0123});
        walk(8, cmd_decode_pkg::DV_MODE, 2, cmd_decode_pkg::DV_NORMAL);
        ctl_u.issue(4'h1, 3'h0, 14'h0);
        expect_cmd(cmd_decode_pkg::CMD_REFRESH);
        walk(8, cmd_decode_pkg::DV_REFRESH, 7, cmd_decode_pkg::DV_NORMAL);
        $display("test mode_refresh done");
    endtask : t_mode

    task automatic t_bank;
        ctl_u.issue(4'h3, 3'h0, 14'h0055);
        expect_cmd(cmd_decode_pkg::CMD_ACT);
        walk(0, cmd_decode_pkg::BK_ACTIVATE, 1, cmd_decode_pkg::BK_ACTIVE);
        ctl_u.issue(4'h5, 3'h0, 14'h0000);
        expect_cmd(cmd_decode_pkg::CMD_READ);
        walk(0, cmd_decode_pkg::BK_READ, 2, cmd_decode_pkg::BK_ACTIVE);
        ctl_u.issue(4'h4, 3'h0, 14'h0000);
        expect_cmd(cmd_decode_pkg::CMD_WRITE);
        walk(0, cmd_decode_pkg::BK_WRITE, 2, cmd_decode_pkg::BK_ACTIVE);
        ctl_u.issue(4'h3, 3'h0, 14'h0055);
        for (int n = 0; n < 8 && illegal_cmd !== 1'b1; n++) @(negedge mclk);
        chk(illegal_cmd, 1'b1);
        chk(bank_state[0], cmd_decode_pkg::BK_ACTIVE);
        ctl_u.issue(4'h2, 3'h0, 14'h0000);
        expect_cmd(cmd_decode_pkg::CMD_PRE);
        walk(0, cmd_decode_pkg::BK_PRECHG, 1, cmd_decode_pkg::BK_IDLE);
        $display("test bank_walk done");
    endtask : t_bank

    task automatic t_auto;
        ctl_u.issue(4'h3, 3'h6, 14'h0001);
        expect_cmd(cmd_decode_pkg::CMD_ACT);
        ctl_u.issue(4'h5, 3'h6, 14'h0400);
        expect_cmd(cmd_decode_pkg::CMD_READ_AP);
        chk(bank_state[6], cmd_decode_pkg::BK_READ_AP);
        chk(bank_state[0], cmd_decode_pkg::BK_IDLE);
        repeat (3) @(negedge mclk);
        chk(bank_state[6], cmd_decode_pkg::BK_IDLE);
        ctl_u.issue(4'h3, 3'h6, 14'h0001);
        expect_cmd(cmd_decode_pkg::CMD_ACT);
        ctl_u.issue(4'h4, 3'h6, 14'h0400);
        expect_cmd(cmd_decode_pkg::CMD_WRITE_AP);
        walk(6, cmd_decode_pkg::BK_WRITE_AP, 4, cmd_decode_pkg::BK_IDLE);
        @(posedge mclk);
        odt_pin <= 1'b1;
        repeat (5) @(negedge mclk);
        chk(odt_active, 1'b1);
        $display("test auto_odt done");
    endtask : t_auto

    task automatic t_power;
        ctl_u.levels(1'b0, 4'h1);
        ctl_u.levels(1'b0, 4'hf);
        expect_cmd(cmd_decode_pkg::CMD_SR_ENTER);
        repeat (4) @(negedge mclk);
        chk({dev_state, odt_active}, {cmd_decode_pkg::DV_SELFREF, 1'b0});
        ctl_u.levels(1'b1, 4'h7);
        expect_cmd(cmd_decode_pkg::CMD_SR_EXIT);
        walk(8, cmd_decode_pkg::DV_XSNR, 7, cmd_decode_pkg::DV_NORMAL);
        chk(odt_active, 1'b1);
        ctl_u.levels(1'b0, 4'hf);
        expect_cmd(cmd_decode_pkg::CMD_PD_ENTER);
        chk(dev_state, cmd_decode_pkg::DV_PWRDN);
        ctl_u.levels(1'b1, 4'hf);
        expect_cmd(cmd_decode_pkg::CMD_PD_EXIT);
        chk(dev_state, cmd_decode_pkg::DV_NORMAL);
        $display("test power_states done");
    endtask : t_power

    task automatic print_verdict;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        rst_n = 1'b0;
        odt_pin = 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk({cmd_code, dev_state, bank_state[0]}, 32'h0);
        ctl_u.issue(4'h7, 3'h0, 14'h0);
        repeat (6) @(negedge mclk);
        t_mode();
        t_bank();
        t_auto();
        t_power();
        print_verdict();
    end
endmodule : tb
